// ==== acsd_ahb_slave.sv ====
`timescale 1ns/10ps
module acsd_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  acsd_reg_if.slave        rif
);

  logic       hit;
  logic       rd_q;
  logic       wr_q;
  logic [7:0] idx_q;

  assign hit = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      idx_q <= acsd_pkg::IDX_NONE;
    end
    else if (hit)
    begin
      rd_q  <= !hwrite;
      wr_q  <= hwrite && (hsize == acsd_pkg::HSIZE_WORD);
      idx_q <= (haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0) ? haddr[9:2] : acsd_pkg::IDX_NONE;
    end
    else
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
  end

  // one wait state on reads keeps read data coming from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_q)
      hrdata <= {24'h00_0000, rif.rdata};
  end

  assign hreadyout = !rd_q;
  assign rif.wr_en = wr_q;
  assign rif.idx   = idx_q;
  assign rif.wdata = hwdata[7:0];

endmodule // acsd_ahb_slave

// ==== acsd_clk_src.sv ====
`timescale 1ns/10ps
// far side: three free-running clock levels, one toggle counter each
module acsd_clk_src (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [23:0] halves,
  output logic             in_clk_buf,
  output logic             pll_clk,
  output logic             decim_clk
);
  logic [2:0] lvl_q;
  logic [7:0] cnt_q [3];

  // levels move just after the edge, like any bench driver
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_q <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_q[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (cnt_q[i] + 8'h01 >= halves[8*i+:8])
        begin
          cnt_q[i] <= 8'h00;
          lvl_q[i] <= ~lvl_q[i];
        end
        else cnt_q[i] <= cnt_q[i] + 8'h01;
      end
    end
  end
  assign in_clk_buf = lvl_q[0];
  assign pll_clk    = lvl_q[1];
  assign decim_clk  = lvl_q[2];
endmodule // acsd_clk_src

// ==== acsd_clk_switch.sv ====
`timescale 1ns/10ps
module acsd_clk_switch (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        src,
  input  acsd_pkg::acsd_src_e    sel,
  output logic                   clk_out_q,
  output logic                   busy
);

  acsd_pkg::acsd_sw_state_e state_q;
  acsd_pkg::acsd_src_e      cur_q;

  // leave a source only while it is low and join the next one only while
  // it is low, so no shortened pulse escapes; a source stuck high stalls here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= acsd_pkg::SW_RUN;
      cur_q   <= acsd_pkg::SRC_IN;
    end
    else
    begin
      case (state_q)
        acsd_pkg::SW_RUN:
        begin
          if (sel != cur_q && !src[cur_q])
            state_q <= acsd_pkg::SW_SWAP;
        end
        acsd_pkg::SW_SWAP:
        begin
          cur_q   <= sel;
          state_q <= acsd_pkg::SW_ARM;
        end
        acsd_pkg::SW_ARM:
        begin
          if (!src[cur_q])
            state_q <= acsd_pkg::SW_RUN;
        end
        default: state_q <= acsd_pkg::SW_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_out_q <= 1'b0;
    else
      clk_out_q <= (state_q == acsd_pkg::SW_RUN) && src[cur_q];
  end

  assign busy = (state_q != acsd_pkg::SW_RUN);

  sw_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q != acsd_pkg::SW_RUN) |-> !clk_out_q)
    else $error("clock switch output high while switching");

  sw_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == acsd_pkg::SW_RUN && $past(state_q) == acsd_pkg::SW_RUN && $stable(cur_q))
      |-> clk_out_q == $past(src[cur_q]))
    else $error("clock switch output does not follow its source");

endmodule // acsd_clk_switch

// ==== acsd_clock_ctrl.sv ====
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
module acsd_clock_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        in_clk_buf,
  input  wire logic        pll_clk,
  input  wire logic        decim_clk,
  output logic             core_sample_clk,
  output logic             output_data_clock,
  output logic             dll_in_reset,
  output logic             pll_clock_on
);

  acsd_reg_if rif ();

  logic                wr;
  logic                ctrl_wr;
  logic                orig_wr;
  logic                srst_go;
  logic [7:0]          dll_ctrl_q;
  logic [1:0]          origin_q;
  logic [2:0]          dec_phase_q;
  logic                pll_gate_q;
  logic [4:0]          srst_cnt_q;
  logic                dll_en;
  logic                loop_output_clock_on;
  logic [2:0]          output_phase_delay_sel;
  logic                duty_fix_en;
  logic                dll_rst_c;
  logic                in_q;
  logic                in_rise;
  logic [2:0]          lock_cnt_q;
  logic                locked;
  logic [7:0]          per_cnt_q;
  logic [7:0]          period_q;
  logic                duty_clk_q;
  logic                duty_cycle_correction;
  logic                pll_gated;
  logic [7:0]          dll_dl_q;
  logic [7:0]          dec_dl_q;
  logic                dll_dly;
  logic                dec_dly;
  logic                loop_path;
  acsd_pkg::acsd_src_e core_sel;
  acsd_pkg::acsd_src_e odc_sel;
  logic                core_busy;
  logic                odc_busy;
  logic [7:0]          rdata_c;

  acsd_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .rif       (rif)
  );

  assign hresp = 1'b0;

  assign wr      = rif.wr_en;
  assign ctrl_wr = wr && (rif.idx == acsd_pkg::IDX_DLL_CTRL);
  assign orig_wr = wr && (rif.idx == acsd_pkg::IDX_ORIGIN);
  assign srst_go = wr && (rif.idx == acsd_pkg::IDX_SOFT_RESET) && rif.wdata[acsd_pkg::SRST_BIT];

  assign dll_en                 = dll_ctrl_q[acsd_pkg::DLL_EN_BIT];
  assign loop_output_clock_on   = dll_ctrl_q[acsd_pkg::LOOP_OUT_BIT];
  assign output_phase_delay_sel = dll_ctrl_q[acsd_pkg::PHASE_LSB +: 3];
  assign duty_fix_en            = dll_ctrl_q[acsd_pkg::DUTY_BIT];

  // software write wins, then the soft-reset set, then the self-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dll_ctrl_q <= acsd_pkg::DLL_CTRL_RST;
    else if (ctrl_wr)
      dll_ctrl_q <= rif.wdata & acsd_pkg::DLL_CTRL_MASK;
    else if (srst_go && dll_en)
      dll_ctrl_q[acsd_pkg::DLL_RST_BIT] <= 1'b1;
    else if (srst_cnt_q == 5'h01)
      dll_ctrl_q[acsd_pkg::DLL_RST_BIT] <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      srst_cnt_q <= 5'h00;
    else if (srst_go && dll_en)
      srst_cnt_q <= 5'(acsd_pkg::SRST_CYCLES);
    else if (srst_cnt_q != 5'h00)
      srst_cnt_q <= srst_cnt_q - 5'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      origin_q    <= acsd_pkg::ORIGIN_RST;
      dec_phase_q <= acsd_pkg::DEC_PHASE_RST;
      pll_gate_q  <= acsd_pkg::PLL_GATE_RST;
    end
    else if (orig_wr)
      origin_q <= rif.wdata[1:0];
    else if (wr && rif.idx == acsd_pkg::IDX_DEC_PHASE)
      dec_phase_q <= rif.wdata[2:0];
    else if (wr && rif.idx == acsd_pkg::IDX_PLL_OUT)
      pll_gate_q <= rif.wdata[acsd_pkg::PLL_GATE_BIT];
  end

  assign dll_rst_c = dll_ctrl_q[acsd_pkg::DLL_RST_BIT] || !dll_en;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dll_in_reset <= 1'b1;
    else
      dll_in_reset <= dll_rst_c;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pll_clock_on <= 1'b0;
    else
      pll_clock_on <= origin_q[acsd_pkg::ORIGIN_BIT] && pll_gate_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      in_q <= 1'b0;
    else
      in_q <= in_clk_buf;
  end

  assign in_rise = in_clk_buf && !in_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_cnt_q <= 3'h0;
    else if (dll_rst_c)
      lock_cnt_q <= 3'h0;
    else if (in_rise && lock_cnt_q != acsd_pkg::LOCK_EDGES)
      lock_cnt_q <= lock_cnt_q + 3'h1;
  end

  assign locked = (lock_cnt_q == acsd_pkg::LOCK_EDGES);

  // period measured in bus clocks; coarse, fine only for slow input clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      per_cnt_q <= 8'h00;
      period_q  <= 8'h00;
    end
    else if (in_rise)
    begin
      per_cnt_q <= 8'h01;
      period_q  <= per_cnt_q;
    end
    else if (per_cnt_q != 8'hff)
      per_cnt_q <= per_cnt_q + 8'h01;
  end

  // rising edge follows the input, falling edge placed at half period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      duty_clk_q <= 1'b0;
    else if (in_rise)
      duty_clk_q <= 1'b1;
    else if (per_cnt_q >= {1'b0, period_q[7:1]})
      duty_clk_q <= 1'b0;
  end

  assign duty_cycle_correction = dll_en && duty_fix_en && locked && !dll_rst_c
                                 && !origin_q[acsd_pkg::ORIGIN_BIT];

  assign pll_gated = pll_clk && pll_gate_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dll_dl_q <= 8'h00;
      dec_dl_q <= 8'h00;
    end
    else
    begin
      dll_dl_q <= {dll_dl_q[6:0], duty_cycle_correction ? (duty_clk_q || in_rise) : in_clk_buf};
      dec_dl_q <= {dec_dl_q[6:0], decim_clk};
    end
  end

  assign dll_dly = dll_dl_q[output_phase_delay_sel];
  assign dec_dly = dec_dl_q[dec_phase_q];

  assign loop_path = dll_en && loop_output_clock_on && locked && !dll_rst_c;

  always_comb
  begin
    if (origin_q[acsd_pkg::ORIGIN_BIT])
      core_sel = acsd_pkg::SRC_PLL;
    else if (duty_cycle_correction)
      core_sel = acsd_pkg::SRC_LOOP;
    else
      core_sel = acsd_pkg::SRC_IN;
  end

  always_comb
  begin
    if (origin_q[acsd_pkg::DECIM_BIT])
      odc_sel = acsd_pkg::SRC_DEC;
    else if (origin_q[acsd_pkg::ORIGIN_BIT])
      odc_sel = acsd_pkg::SRC_PLL;
    else if (loop_path)
      odc_sel = acsd_pkg::SRC_LOOP;
    else
      odc_sel = acsd_pkg::SRC_IN;
  end

  acsd_clk_switch u_core_sw (
    .clk       (hclk),
    .rst_n     (hresetn),
    .src       ({1'b0, pll_gated, duty_clk_q || in_rise, in_clk_buf}),
    .sel       (core_sel),
    .clk_out_q (core_sample_clk),
    .busy      (core_busy)
  );

  acsd_clk_switch u_odc_sw (
    .clk       (hclk),
    .rst_n     (hresetn),
    .src       ({dec_dly, core_sample_clk, dll_dly, in_clk_buf}),
    .sel       (odc_sel),
    .clk_out_q (output_data_clock),
    .busy      (odc_busy)
  );

  always_comb
  begin
    if (rif.idx == acsd_pkg::IDX_DLL_CTRL)
      rdata_c = dll_ctrl_q;
    else if (rif.idx == acsd_pkg::IDX_ORIGIN)
      rdata_c = {6'h00, origin_q};
    else if (rif.idx == acsd_pkg::IDX_DEC_PHASE)
      rdata_c = {5'h00, dec_phase_q};
    else if (rif.idx == acsd_pkg::IDX_PLL_OUT)
      rdata_c = {7'h00, pll_gate_q};
    else if (rif.idx == acsd_pkg::IDX_STATUS)
      rdata_c = {3'h0, duty_cycle_correction, odc_busy, core_busy, dll_rst_c, locked};
    else
      rdata_c = 8'h00;
  end

  assign rif.rdata = rdata_c;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  origin_hold_a: assert property (!origin_q[0] && !orig_wr |=> !origin_q[0])
    else $error("clock origin left the input clock without a write");
  core_raw_a: assert property (core_sel == acsd_pkg::SRC_IN && u_core_sw.cur_q == acsd_pkg::SRC_IN && !core_busy
    && $past(!core_busy) && $stable(core_sel) |=> core_sample_clk == $past(in_clk_buf))
    else $error("core clock does not follow the input buffer");
  core_pll_a: assert property (origin_q[0] && u_core_sw.cur_q == acsd_pkg::SRC_PLL && !core_busy && $stable(core_sel)
    && $past(!core_busy) |=> core_sample_clk == $past(pll_gated))
    else $error("core clock does not follow the gated PLL clock");
  pll_gate_a: assert property (!pll_gate_q && origin_q[0] && u_core_sw.cur_q == acsd_pkg::SRC_PLL && !core_busy
    ##1 !pll_gate_q |-> !core_sample_clk)
    else $error("PLL clock reached the core while gated off");
  odc_raw_a: assert property (!origin_q[1] && !origin_q[0] && !loop_path |-> odc_sel == acsd_pkg::SRC_IN)
    else $error("data clock not taken from the input buffer");
  odc_decim_a: assert property (origin_q[1] |-> odc_sel == acsd_pkg::SRC_DEC)
    else $error("decimation does not own the data clock");
  loop_off_a: assert property (!dll_en |-> !loop_path && !duty_cycle_correction ##1 lock_cnt_q == 3'h0)
    else $error("loop features active while loop disabled");
  loop_gate_a: assert property (!loop_output_clock_on && !origin_q[1] |-> odc_sel != acsd_pkg::SRC_LOOP)
    else $error("loop output reached data clock while gated");
  dll_phase_a: assert property (output_phase_delay_sel == 3'h3 |-> dll_dly == $past(dll_dl_q[0], 3))
    else $error("loop phase tap does not match its field");
  dec_phase_a: assert property (dec_phase_q == 3'h2 |-> dec_dly == $past(decim_clk, 3))
    else $error("decimation phase tap does not match its field");
  duty_rise_a: assert property (in_rise && duty_cycle_correction |=> duty_clk_q)
    else $error("corrected clock rising edge moved");
  duty_pll_a: assert property (origin_q[0] |-> !duty_cycle_correction)
    else $error("correction applied to the PLL clock");
  dll_hold_a: assert property (dll_ctrl_q[6] && !ctrl_wr && srst_cnt_q != 5'h01 |=> dll_ctrl_q[6])
    else $error("loop reset released without software");
  srst_hold_a: assert property (srst_go && dll_en && !ctrl_wr |=> ##1 dll_in_reset [*8])
    else $error("soft reset did not hold the loop in reset");
  srst_clear_a: assert property (srst_cnt_q == 5'h01 && !ctrl_wr && !srst_go |=> !dll_ctrl_q[6])
    else $error("loop reset bit not cleared after soft reset");

  pll_switch_c: cover property (!origin_q[0] ##1 origin_q[0] ##[1:40] !core_busy);
  duty_on_c: cover property ($rose(duty_cycle_correction));
  srst_done_c: cover property (srst_cnt_q == 5'h01 ##1 !dll_ctrl_q[6]);
  decim_c: cover property ($rose(origin_q[1]) ##[1:40] !odc_busy);

endmodule // acsd_clock_ctrl

// ==== acsd_pkg.sv ====
package acsd_pkg;

  // bus clock and derived counts
  localparam int unsigned CLK_PERIOD_PS  = 8000;
  localparam int unsigned SRST_TIME_NS   = 128;
  localparam int unsigned SRST_CYCLES    = (SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SOFT_RESET  = 8'h00;
  localparam logic [7:0] IDX_DLL_CTRL    = 8'h52;
  localparam logic [7:0] IDX_ORIGIN      = 8'h53;
  localparam logic [7:0] IDX_DEC_PHASE   = 8'h64;
  localparam logic [7:0] IDX_PLL_OUT     = 8'h6d;
  localparam logic [7:0] IDX_STATUS      = 8'h70;
  localparam logic [7:0] IDX_NONE        = 8'hff;

  // dll_clock_control fields
  localparam int unsigned DLL_EN_BIT     = 0;
  localparam int unsigned LOOP_OUT_BIT   = 1;
  localparam int unsigned PHASE_LSB      = 2;
  localparam int unsigned DUTY_BIT       = 5;
  localparam int unsigned DLL_RST_BIT    = 6;
  localparam logic [7:0]  DLL_CTRL_MASK  = 8'h7f;
  localparam logic [7:0]  DLL_CTRL_RST   = 8'h40;

  // clock_origin_control, pll output and soft reset fields
  localparam int unsigned ORIGIN_BIT     = 0;
  localparam int unsigned DECIM_BIT      = 1;
  localparam logic [1:0]  ORIGIN_RST     = 2'h0;
  localparam logic [2:0]  DEC_PHASE_RST  = 3'h0;
  localparam int unsigned PLL_GATE_BIT   = 0;
  localparam logic        PLL_GATE_RST   = 1'b0;
  localparam int unsigned SRST_BIT       = 0;

  // loop lock: input rising edges seen after reset release
  localparam logic [2:0]  LOCK_EDGES     = 3'h4;

  // bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  typedef enum logic [1:0] {
    SRC_IN   = 2'h0,
    SRC_LOOP = 2'h1,
    SRC_PLL  = 2'h2,
    SRC_DEC  = 2'h3
  } acsd_src_e;

  typedef enum logic [2:0] {
    SW_RUN  = 3'h1,
    SW_SWAP = 3'h2,
    SW_ARM  = 3'h4
  } acsd_sw_state_e;

endpackage

// ==== acsd_reg_if.sv ====
`timescale 1ns/10ps
interface acsd_reg_if;
  logic       wr_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport regs  (input wr_en, input idx, input wdata, output rdata);
endinterface

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        in_clk_buf, pll_clk, decim_clk, core_sample_clk, output_data_clock;
  logic        dll_in_reset, pll_clock_on, rdy_q;
  logic [23:0] halves;
  logic [31:0] q;
  int          n_errors, checked, cyc, a, b;
  logic [7:0]  tidx [4] = '{8'h52, 8'h53, 8'h64, 8'h6d};

  acsd_clock_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_clk_buf(in_clk_buf),
    .pll_clk(pll_clk), .decim_clk(decim_clk), .core_sample_clk(core_sample_clk),
    .output_data_clock(output_data_clock), .dll_in_reset(dll_in_reset),
    .pll_clock_on(pll_clock_on));
  acsd_clk_src src (.hclk(hclk), .hresetn(hresetn), .halves(halves), .in_clk_buf(in_clk_buf),
    .pll_clk(pll_clk), .decim_clk(decim_clk));

  always #4 hclk = ~hclk;
  // bus answers captured mid-cycle, so the edge never races the slave
  always @(negedge hclk)
  begin
    rdy_q = hreadyout;
    rd_q  = hrdata;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] rmask(input logic [7:0] idx);
    case (idx)
      8'h52:   return 8'h7f;
      8'h53:   return 8'h03;
      8'h64:   return 8'h07;
      8'h6d:   return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  // edge counts drift by one with the window phase
  task automatic chk_cnt(input string nm, input int e, input int g, input int tol);
    checked++;
    if (g > e + tol || g < e - tol)
    begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= w;
    hsize  <= sz;
    do @(posedge hclk); while (rdy_q !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (rdy_q !== 1'b1);
    q = rd_q;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 3'h2);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 3'h2);
    chk_reg("register", {24'h0, e}, q);
  endtask

  task automatic count(input logic sel, input int n, output int c);
    logic p, o;
    c = 0;
    p = sel ? output_data_clock : core_sample_clk;
    repeat (n)
    begin
      @(negedge hclk);
      o = p;
      p = sel ? output_data_clock : core_sample_clk;
      if (p && !o) c++;
    end
  endtask
  // cycles from an input rise to the next rise of the chosen output
  task automatic lag(input logic sel, output int n);
    logic p, o;
    p = in_clk_buf;
    do begin @(negedge hclk); o = p; p = in_clk_buf; end while (!(p && !o));
    n = 0;
    p = sel ? output_data_clock : core_sample_clk;
    do begin @(negedge hclk); n++; o = p; p = sel ? output_data_clock : core_sample_clk; end
    while (!(p && !o) && n < 40);
  endtask

  initial
  begin
    hclk = 0; hresetn = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; halves = {8'h05, 8'h02, 8'h03};
    // clean falling edge so every flop is reset before the first clock
    #1 hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'h387e));
    chk_bit("loop held", 1'b1, dll_in_reset);
    chk_bit("pll gate", 1'b0, pll_clock_on);
    chk_bit("response", 1'b0, hresp);
    foreach (tidx[i]) rd_chk(tidx[i], (i == 0) ? 8'h40 : 8'h00);
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    $display("test reset done");

    repeat (8)
    begin
      a = $urandom % 4;
      b = $urandom % 256;
      wr(tidx[a], b[7:0]);
      rd_chk(tidx[a], b[7:0] & rmask(tidx[a]));
    end
    wr(8'h64, 8'h02);
    bus(1'b1, 8'h64, 8'h05, 3'h0);
    rd_chk(8'h64, 8'h02);
    foreach (tidx[i]) wr(tidx[i], (i == 0) ? 8'h40 : 8'h00);
    rd_chk(8'h64, 8'h00);
    $display("test registers done");

    count(1'b0, 96, a);
    chk_cnt("core edges", 16, a, 1);
    count(1'b1, 96, a);
    chk_cnt("data edges", 16, a, 1);
    wr(8'h53, 8'h01);
    wr(8'h6d, 8'h01);
    repeat (16) @(negedge hclk);
    chk_bit("pll gate", 1'b1, pll_clock_on);
    count(1'b0, 96, a);
    chk_cnt("core edges", 24, a, 1);
    wr(8'h53, 8'h03);
    repeat (24) @(negedge hclk);
    count(1'b1, 100, a);
    chk_cnt("data edges", 10, a, 1);
    wr(8'h53, 8'h00);
    wr(8'h6d, 8'h00);
    repeat (8) @(negedge hclk);
    chk_bit("pll gate", 1'b0, pll_clock_on);
    $display("test sources done");

    wr(8'h52, 8'h01);
    repeat (40) @(negedge hclk);
    chk_bit("loop held", 1'b0, dll_in_reset);
    bus(1'b0, 8'h70, 8'h00, 3'h2);
    chk_bit("locked", 1'b1, q[0]);
    wr(8'h00, 8'h01);
    repeat (2) @(negedge hclk);
    chk_bit("loop held", 1'b1, dll_in_reset);
    rd_chk(8'h52, 8'h41);
    repeat (30) @(negedge hclk);
    rd_chk(8'h52, 8'h01);
    chk_bit("loop held", 1'b0, dll_in_reset);
    $display("test loop reset done");

    halves <= {8'h05, 8'h02, 8'h08};
    wr(8'h52, 8'h41);
    wr(8'h52, 8'h03);
    // four rises of a 16-cycle input clock before lock
    repeat (80) @(negedge hclk);
    lag(1'b1, a);
    wr(8'h52, 8'h1f);
    repeat (40) @(negedge hclk);
    lag(1'b1, b);
    chk_cnt("phase step", 7, b - a, 0);
    $display("test phase done");

    wr(8'h52, 8'h01);
    repeat (40) @(negedge hclk);
    lag(1'b0, a);
    wr(8'h52, 8'h21);
    repeat (40) @(negedge hclk);
    lag(1'b0, b);
    chk_cnt("rise lag", a, b, 0);
    wr(8'h53, 8'h01);
    wr(8'h6d, 8'h01);
    repeat (24) @(negedge hclk);
    count(1'b0, 96, a);
    chk_cnt("core edges", 24, a, 1);
    $display("test correction done");
    stop_test();
  end
endmodule // tb_top
